// File: hw/eas_map.vh
// Purpose: constants for the smart sequencer
// Assumes: included by bare name
// Notes:   definitions only
`ifndef EAS_MAP_VH
`define EAS_MAP_VH
// ----------------------------------------
// sizes
// ----------------------------------------
`define EAS_MAX_STEPS     20
`define EAS_IDX_W         5
`define EAS_CMP_NUM       4
`define EAS_LR_NUM        4
`define EAS_VAR_W         16
`define EAS_STAT_W        8
// ----------------------------------------
// event source select codes (bits 4:3 kind, 2:0 index)
// ----------------------------------------
`define EAS_SRC_W         5
`define EAS_SRC_STATUS    2'h0
`define EAS_SRC_LOGIC     2'h1
`define EAS_SRC_COMP      2'h2
`define EAS_SRC_TRUE      2'h3
// ----------------------------------------
// comparator operators
// ----------------------------------------
`define EAS_CMP_LT        2'h0
`define EAS_CMP_EQ        2'h1
`define EAS_CMP_GT        2'h2
// ----------------------------------------
// logic rule operators
// ----------------------------------------
`define EAS_LOP_AND       2'h0
`define EAS_LOP_OR        2'h1
`define EAS_LOP_AND_NOT   2'h2
`define EAS_LOP_OR_NOT    2'h3
`define EAS_LIN_W         4
`endif

// File: hw/eas_logic_rule.v
// Purpose: one three-input boolean logic rule
// Assumes: inputs already on sys_clk
// Notes:   result registered
`timescale 1ns/100ps
`default_nettype none
`include "eas_map.vh"
module eas_logic_rule (
    // clock and reset
    input  wire       sys_clk,
    input  wire       sys_rst,
    // operands and operators
    input  wire [2:0] in_bits,
    input  wire [1:0] op_a,
    input  wire [1:0] op_b,
    // result
    output reg        result_ff
);
    reg ab;
    reg abc;
    // ----------------------------------------
    // combine up to three inputs
    // ----------------------------------------
    always @* begin
        case (op_a)
            `EAS_LOP_AND:     ab = in_bits[0] & in_bits[1];
            `EAS_LOP_OR:      ab = in_bits[0] | in_bits[1];
            `EAS_LOP_AND_NOT: ab = in_bits[0] & ~in_bits[1];
            default:          ab = in_bits[0] | ~in_bits[1];
        endcase
        case (op_b)
            `EAS_LOP_AND:     abc = ab & in_bits[2];
            `EAS_LOP_OR:      abc = ab | in_bits[2];
            `EAS_LOP_AND_NOT: abc = ab & ~in_bits[2];
            default:          abc = ab | ~in_bits[2];
        endcase
    end
    always @(posedge sys_clk) begin
        if (sys_rst)
            result_ff <= 1'b0;
        else
            result_ff <= abc;
    end
endmodule
`default_nettype wire

// File: hw/eas_smart_sequencer.v
// Purpose: event/action smart sequencer for a motor drive
// Assumes: scan_tick, variables and config on sys_clk; dig_in from pins
// Notes:   one event tested per scan tick
//
// Function
// - action fires only when paired event true
// - event n triggers action n, zero based
// - after action, advance to next index
// - exactly one event evaluated at a time
// - false event: no action, same index
// - on start only event zero is tested
// - step count configurable from one to twenty
// - after last action wrap to zero
// - event is status, logic rule, comparator or always true
// - comparator: variable against fixed preset
// - logic rule: three inputs, AND OR NOT
`timescale 1ns/100ps
`default_nettype none
`include "eas_map.vh"
module eas_smart_sequencer #(
    parameter MAX_STEPS = `EAS_MAX_STEPS,
    parameter IDX_W     = `EAS_IDX_W,
    parameter VAR_W     = `EAS_VAR_W,
    parameter STAT_W    = `EAS_STAT_W,
    parameter ACT_W     = 8
) (
    // clock and reset
    input  wire                              sys_clk,
    input  wire                              sys_rst,
    // control
    input  wire                              seq_start,
    input  wire                              seq_stop,
    input  wire                              scan_tick,
    input  wire [IDX_W-1:0]                  step_count,
    // event sources
    input  wire [STAT_W-1:0]                 status_bits,
    input  wire [3:0]                        dig_in,
    input  wire [4*VAR_W-1:0]                cmp_var,
    input  wire [4*VAR_W-1:0]                cmp_preset,
    input  wire [7:0]                        cmp_op,
    input  wire [4*3*`EAS_LIN_W-1:0]         lr_sel,
    input  wire [15:0]                       lr_op,
    // step program, one entry per index
    input  wire [MAX_STEPS*`EAS_SRC_W-1:0]   event_sel,
    input  wire [MAX_STEPS*ACT_W-1:0]        action_code,
    // outputs
    output reg                               running_ff,
    output reg  [IDX_W-1:0]                  step_idx_ff,
    output reg                               action_fire_ff,
    output reg  [ACT_W-1:0]                  action_out_ff,
    output reg  [IDX_W-1:0]                  action_idx_ff,
    output reg  [3:0]                        cmp_res_ff,
    output reg  [3:0]                        lr_res_ff
);
    localparam ST_IDLE = 2'b01;
    localparam ST_RUN  = 2'b10;

    reg  [1:0]                 state_ff;
    reg  [1:0]                 nxt_state;
    reg  [IDX_W-1:0]           nxt_idx;
    reg                        nxt_fire;
    reg  [3:0]                 din_s1_ff;
    reg  [3:0]                 din_s2_ff;
    reg                        ev_true_ff;
    reg  [3:0]                 nxt_cmp;
    reg  [15:0]                lr_pool;
    reg  [`EAS_SRC_W-1:0]      cur_sel;
    reg                        cur_true;
    reg  [IDX_W-1:0]           last_idx;
    wire [3:0]                 lr_wire;
    integer                    i;
    genvar                     g;

    // ----------------------------------------
    // pin synchroniser for digital inputs
    // ----------------------------------------
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            din_s1_ff <= 4'h0;
            din_s2_ff <= 4'h0;
        end else begin
            din_s1_ff <= dig_in;
            din_s2_ff <= din_s1_ff;
        end
    end

    // ----------------------------------------
    // comparators
    // ----------------------------------------
    always @* begin
        for (i = 0; i < 4; i = i + 1) begin
            case (cmp_op[2*i +: 2])
                `EAS_CMP_LT: nxt_cmp[i] = cmp_var[VAR_W*i +: VAR_W]
                                          < cmp_preset[VAR_W*i +: VAR_W];
                `EAS_CMP_EQ: nxt_cmp[i] = cmp_var[VAR_W*i +: VAR_W]
                                          == cmp_preset[VAR_W*i +: VAR_W];
                `EAS_CMP_GT: nxt_cmp[i] = cmp_var[VAR_W*i +: VAR_W]
                                          > cmp_preset[VAR_W*i +: VAR_W];
                default:     nxt_cmp[i] = 1'b0;
            endcase
        end
    end

    always @(posedge sys_clk) begin
        if (sys_rst)
            cmp_res_ff <= 4'h0;
        else
            cmp_res_ff <= nxt_cmp;
    end

    // ----------------------------------------
    // logic rules
    // ----------------------------------------
    // input pool: 0-3 comparators, 4-7 digital inputs,
    // 8-11 status bits, 12 last event, 13-15 rules 0 to 2
    always @* begin
        lr_pool        = 16'h0000;
        lr_pool[3:0]   = cmp_res_ff;
        lr_pool[7:4]   = din_s2_ff;
        lr_pool[11:8]  = status_bits[3:0];
        lr_pool[12]    = ev_true_ff;
        lr_pool[15:13] = lr_res_ff[2:0];
    end

    generate
        for (g = 0; g < 4; g = g + 1) begin : gen_lr
            eas_logic_rule u_rule (
                .sys_clk   (sys_clk),
                .sys_rst   (sys_rst),
                .in_bits   ({lr_pool[lr_sel[(3*g+2)*`EAS_LIN_W +: `EAS_LIN_W]],
                             lr_pool[lr_sel[(3*g+1)*`EAS_LIN_W +: `EAS_LIN_W]],
                             lr_pool[lr_sel[(3*g)*`EAS_LIN_W +: `EAS_LIN_W]]}),
                .op_a      (lr_op[4*g +: 2]),
                .op_b      (lr_op[4*g+2 +: 2]),
                .result_ff (lr_wire[g])
            );
        end
    endgenerate

    always @(posedge sys_clk) begin
        if (sys_rst)
            lr_res_ff <= 4'h0;
        else
            lr_res_ff <= lr_wire;
    end

    // ----------------------------------------
    // current event: only the indexed one is tested
    // ----------------------------------------
    always @* begin
        cur_sel = event_sel[step_idx_ff*`EAS_SRC_W +: `EAS_SRC_W];
        case (cur_sel[4:3])
            `EAS_SRC_STATUS: cur_true = status_bits[cur_sel[2:0]];
            `EAS_SRC_LOGIC:  cur_true = lr_wire[cur_sel[1:0]];
            `EAS_SRC_COMP:   cur_true = cmp_res_ff[cur_sel[1:0]];
            default:         cur_true = 1'b1;
        endcase
    end

    // ----------------------------------------
    // step count clamp to 1..MAX_STEPS
    // ----------------------------------------
    always @* begin
        if (step_count == {IDX_W{1'b0}})
            last_idx = {IDX_W{1'b0}};
        else if (step_count > MAX_STEPS[IDX_W-1:0])
            last_idx = MAX_STEPS[IDX_W-1:0] - 1'b1;
        else
            last_idx = step_count - 1'b1;
    end

    // ----------------------------------------
    // sequencer state machine
    // ----------------------------------------
    always @* begin
        nxt_state = state_ff;
        nxt_idx   = step_idx_ff;
        nxt_fire  = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (seq_start) begin
                    nxt_state = ST_RUN;
                    nxt_idx   = {IDX_W{1'b0}};
                end
            end
            ST_RUN: begin
                if (seq_stop) begin
                    nxt_state = ST_IDLE;
                end else if (seq_start) begin
                    nxt_idx = {IDX_W{1'b0}};
                end else if (scan_tick && cur_true) begin
                    nxt_fire = 1'b1;
                    if (step_idx_ff >= last_idx)
                        nxt_idx = {IDX_W{1'b0}};
                    else
                        nxt_idx = step_idx_ff + 1'b1;
                end
                // false event keeps index and fires nothing
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_idx   = {IDX_W{1'b0}};
            end
        endcase
    end

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            state_ff       <= ST_IDLE;
            running_ff     <= 1'b0;
            step_idx_ff    <= {IDX_W{1'b0}};
            action_fire_ff <= 1'b0;
            action_out_ff  <= {ACT_W{1'b0}};
            action_idx_ff  <= {IDX_W{1'b0}};
            ev_true_ff     <= 1'b0;
        end else begin
            state_ff       <= nxt_state;
            running_ff     <= (nxt_state == ST_RUN);
            step_idx_ff    <= nxt_idx;
            action_fire_ff <= nxt_fire;
            if (scan_tick && state_ff == ST_RUN)
                ev_true_ff <= cur_true;
            if (nxt_fire) begin
                action_out_ff <= action_code[step_idx_ff*ACT_W +: ACT_W];
                action_idx_ff <= step_idx_ff;
            end
        end
    end
endmodule
`default_nettype wire

// File: sim/eas_seq_props.sv
// Purpose: port assertions for the smart sequencer
// Assumes: step_count steady while running
// Notes:   logic-rule events are judged by the bench
`timescale 1ns/100ps
`default_nettype none
`include "eas_map.vh"
module eas_seq_props #(
    parameter MAX_STEPS = 20,
    parameter IDX_W     = 5,
    parameter VAR_W     = 16,
    parameter STAT_W    = 8,
    parameter ACT_W     = 8
) (
    // watched ports
    input wire logic                         sys_clk,
    input wire logic                         sys_rst,
    input wire logic                         seq_start,
    input wire logic                         seq_stop,
    input wire logic                         scan_tick,
    input wire logic [IDX_W-1:0]             step_count,
    input wire logic [STAT_W-1:0]            status_bits,
    input wire logic [4*VAR_W-1:0]           cmp_var,
    input wire logic [4*VAR_W-1:0]           cmp_preset,
    input wire logic [7:0]                   cmp_op,
    input wire logic [MAX_STEPS*5-1:0]       event_sel,
    input wire logic [MAX_STEPS*ACT_W-1:0]   action_code,
    input wire logic                         running_ff,
    input wire logic [IDX_W-1:0]             step_idx_ff,
    input wire logic                         action_fire_ff,
    input wire logic [ACT_W-1:0]             action_out_ff,
    input wire logic [IDX_W-1:0]             action_idx_ff,
    input wire logic [3:0]                   cmp_res_ff
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    wire [4:0]       esel     = event_sel[step_idx_ff*5 +: 5];
    wire [ACT_W-1:0] act_now  = action_code[step_idx_ff*ACT_W +: ACT_W];
    wire             ev_known = esel[4:3] != 2'h1 && !(esel[4:3] == 2'h2 && esel[2]);
    wire             ev_true  = esel[4:3] == 2'h3 ||
        (esel[4:3] == 2'h0 ? status_bits[esel[2:0]] : cmp_res_ff[esel[1:0]]);
    wire [IDX_W-1:0] last_idx = step_count == 0 ? 0 :
        step_count > MAX_STEPS ? MAX_STEPS - 1 : step_count - 1;
    logic [3:0]       cmp_exp;
    logic [VAR_W-1:0] cv, cp;
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            cv = cmp_var[VAR_W*k +: VAR_W];
            cp = cmp_preset[VAR_W*k +: VAR_W];
            case (cmp_op[2*k +: 2])
                2'h0: cmp_exp[k] = cv < cp;
                2'h1: cmp_exp[k] = cv == cp;
                2'h2: cmp_exp[k] = cv > cp;
                default: cmp_exp[k] = 1'b0;
            endcase
        end
    end
    sequence s_true_tick;
        running_ff && scan_tick && ev_known && ev_true && !seq_start && !seq_stop;
    endsequence
    sequence s_fired;
        action_fire_ff && action_idx_ff == $past(step_idx_ff) && action_out_ff == $past(act_now);
    endsequence
    AST_TRUE_FIRES: assert property (s_true_tick |=> s_fired)
        else $error("true event did not fire its paired action");
    AST_FIRE_CAUSE: assert property (action_fire_ff |-> $past(running_ff && scan_tick))
        else $error("action fired without a running scan tick");
    AST_ADVANCE: assert property (action_fire_ff |-> step_idx_ff ==
        ($past(step_idx_ff) == $past(last_idx) ? 0 : $past(step_idx_ff) + 1))
        else $error("index did not advance or wrap correctly");
    AST_FALSE_HOLD: assert property (running_ff && !seq_start && !seq_stop &&
        !(scan_tick && ev_true) && (!scan_tick || ev_known) |=> $stable(step_idx_ff) && !action_fire_ff)
        else $error("index moved or action fired without a true event");
    AST_IDLE_TICK: assert property (!running_ff && !seq_start |=> !action_fire_ff)
        else $error("action fired while idle");
    AST_START: assert property (!running_ff && seq_start && !seq_stop |=>
        running_ff && step_idx_ff == 0)
        else $error("start did not run from index zero");
    AST_STOP: assert property (running_ff && seq_stop |=> !running_ff)
        else $error("stop did not return to idle");
    AST_CMP: assert property (!$past(sys_rst) |-> cmp_res_ff == $past(cmp_exp))
        else $error("comparator result wrong");
endmodule
`default_nettype wire

// File: sim/eas_smart_sequencer_tb.sv
// Purpose: random and corner tests of the smart sequencer
// Assumes: inputs driven 1 ns after the rising edge
// Notes:   rules 0-2 read status bits 0 to 2, rule 3 digital inputs 0 to 2
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module eas_smart_sequencer_tb;
    logic         sys_clk = 0, sys_rst = 1, seq_start = 0, seq_stop = 0, scan_tick = 0;
    logic [4:0]   step_count = 5'h01;
    logic [7:0]   status_bits = 8'h00, cmp_op = 8'h00;
    logic [3:0]   dig_in = 4'h0;
    logic [63:0]  cmp_var = 64'h0, cmp_preset = 64'h0;
    logic [47:0]  lr_sel = {12'h654, {3{12'hA98}}};
    logic [15:0]  lr_op = 16'h0000;
    logic [99:0]  event_sel = 100'h0;
    logic [159:0] action_code = 160'h0;
    logic [31:0]  k;
    logic [4:0]   counts [6] = '{5'h01, 5'h14, 5'h00, 5'h1F, 5'h03, 5'h0B};
    wire          running_ff, action_fire_ff;
    wire  [4:0]   step_idx_ff, action_idx_ff;
    wire  [7:0]   action_out_ff;
    wire  [3:0]   cmp_res_ff, lr_res_ff;
    int           seed = 20, bad_count = 0, samples_checked = 0, exp_idx = 0, last = 0;
    bit           run = 0;
    always #5 sys_clk = ~sys_clk;
    eas_smart_sequencer eas_smart_sequencer_inst (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .seq_start(seq_start), .seq_stop(seq_stop),
        .scan_tick(scan_tick), .step_count(step_count), .status_bits(status_bits),
        .dig_in(dig_in), .cmp_var(cmp_var), .cmp_preset(cmp_preset), .cmp_op(cmp_op),
        .lr_sel(lr_sel), .lr_op(lr_op), .event_sel(event_sel), .action_code(action_code),
        .running_ff(running_ff), .step_idx_ff(step_idx_ff),
        .action_fire_ff(action_fire_ff), .action_out_ff(action_out_ff),
        .action_idx_ff(action_idx_ff), .cmp_res_ff(cmp_res_ff), .lr_res_ff(lr_res_ff));
    function automatic logic lop(input logic [1:0] op, input logic x, y);
        return op[0] ? x | (y ^ op[1]) : x & (y ^ op[1]);
    endfunction
    // pool entries used here: 4-7 digital inputs, 8-11 status bits
    function automatic logic pool(input logic [3:0] n);
        return n[3] ? status_bits[n[1:0]] : dig_in[n[1:0]];
    endfunction
    function automatic logic rule_exp(input int g);
        logic [11:0] s = lr_sel[12*g +: 12];
        return lop(lr_op[4*g+2 +: 2], lop(lr_op[4*g +: 2], pool(s[3:0]), pool(s[7:4])),
            pool(s[11:8]));
    endfunction
    function automatic logic ev_exp(input logic [4:0] s);
        int          i = s[2:0];
        logic [15:0] v = cmp_var[16*i +: 16], p = cmp_preset[16*i +: 16];
        case (s[4:3])
            2'h0: return status_bits[i];
            2'h1: return rule_exp(i);
            2'h2: return cmp_op[2*i +: 2] == 2'h0 ? v < p : cmp_op[2*i +: 2] == 2'h1 ? v == p :
                cmp_op[2*i +: 2] == 2'h2 && v > p;
            default: return 1'b1;
        endcase
    endfunction
    // n back-to-back scan ticks, each checked in the cycle after it
    task automatic tick(input int n);
        logic f;
        @(posedge sys_clk) #1 scan_tick = 1;
        repeat (n) begin
            f = run && ev_exp(event_sel[5*exp_idx +: 5]);
            @(posedge sys_clk) #1;
            `CHK(action_fire_ff, f)
            if (f) begin
                `CHK(action_idx_ff, exp_idx[4:0])
                `CHK(action_out_ff, action_code[8*exp_idx +: 8])
                exp_idx = exp_idx == last ? 0 : exp_idx + 1;
            end
            `CHK(step_idx_ff, exp_idx[4:0])
        end
        scan_tick = 0;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        #1 sys_rst = 0;
        `CHK({running_ff, step_idx_ff, action_fire_ff}, 7'h00)
        tick(1);
        for (int ph = 0; ph < 6; ph++) begin
            @(posedge sys_clk) #1 step_count = counts[ph];
            last = step_count == 0 ? 0 : step_count > 20 ? 19 : step_count - 1;
            for (int i = 0; i < 20; i++) begin
                k = $random(seed);
                event_sel[5*i +: 5] = {k[4:3], k[4:3] == 2'h0 ? k[2] : 1'b0, k[1:0]};
                action_code[8*i +: 8] = 8'($random(seed));
            end
            seq_start = 1;
            @(posedge sys_clk) #1 seq_start = 0;
            exp_idx = 0;
            run = 1;
            `CHK({running_ff, step_idx_ff}, 6'h20)
            repeat (50) begin
                k = $random(seed);
                {status_bits, cmp_op, dig_in} = k[19:0];
                cmp_var = {$random(seed), $random(seed)} & {4{16'h0003}};
                cmp_preset = {$random(seed), $random(seed)} & {4{16'h0003}};
                lr_op = 16'($random(seed));
                repeat (3) @(posedge sys_clk);
                tick(1 + k[20] + k[21]);
                for (int g = 0; g < 4; g++)
                    `CHK(lr_res_ff[g], rule_exp(g))
            end
        end
        // restart, two sure steps, stop with the index held, then reset from there
        event_sel = {20{5'h18}};
        seq_start = 1;
        @(posedge sys_clk) #1 seq_start = 0;
        exp_idx = 0;
        tick(2);
        @(posedge sys_clk) #1 seq_stop = 1;
        @(posedge sys_clk) #1 seq_stop = 0;
        `CHK({running_ff, step_idx_ff}, {1'b0, exp_idx[4:0]})
        sys_rst = 1;
        @(posedge sys_clk) #1 sys_rst = 0;
        `CHK({running_ff, step_idx_ff, action_fire_ff}, 7'h00)
        test_done();
    end
    initial begin
        #200000;
        bad_count++;
        test_done();
    end
endmodule
bind eas_smart_sequencer eas_seq_props #(.MAX_STEPS(MAX_STEPS), .IDX_W(IDX_W),
    .VAR_W(VAR_W), .STAT_W(STAT_W), .ACT_W(ACT_W)) eas_seq_props_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .seq_start(seq_start), .seq_stop(seq_stop),
    .scan_tick(scan_tick), .step_count(step_count), .status_bits(status_bits),
    .cmp_var(cmp_var), .cmp_preset(cmp_preset), .cmp_op(cmp_op), .event_sel(event_sel),
    .action_code(action_code), .running_ff(running_ff), .step_idx_ff(step_idx_ff),
    .action_fire_ff(action_fire_ff), .action_out_ff(action_out_ff),
    .action_idx_ff(action_idx_ff), .cmp_res_ff(cmp_res_ff));
`default_nettype wire
